// ===== rtl/hs_counter_compare_irq.sv
// Four high-speed pulse counters with table comparison and interrupt task dispatch.
// Assumes a classic Wishbone master on i_clk and asynchronous encoder and expansion inputs.
// Summary of operation
// - Match suspends cyclic work until task completes.
// - Target table: count word, low, high, control.
// - Control bit 15 direction, bits 0-7 task.
// - Range entry: lower, upper, then task word.
// - Task word all ones disables the range.
// - Value inside range limits starts its task.
// - Comparison starts only on conditioned table or start command.
// - Each counter counts linear or ring mode.
// - Two selectable reset methods (index or software only), optionally continuing comparison.
// - Gate bit holds value or keeps counting.
// - Quadrature 4x, pulse-direction, up-down, increment inputs.
// - Count at 1 MHz and below reliably.
// - Four independent counters, each with own table.
// - Expansion interrupts always accepted, run named task.
// - Shared task number runs once per source.
// - Frequency measured on one selected counter only.
// - Table command code picks register and start.
// - Do-not-start code keeps range, suppresses task.
//
// The address map and the Wishbone slave port are this design's own decisions.
`include "hsc_map.svh"
module hs_counter_compare_irq
	import hsc_pkg::*;
#(
	parameter int FREQ_WIN_CYC = `FREQ_WIN_US * `CLK_MHZ
) (
	// Clock and reset.
	input  wire logic                             i_clk,
	input  wire logic                             i_rst_b,
	// Wishbone slave.
	input  wire logic                             i_wb_cyc,
	input  wire logic                             i_wb_stb,
	input  wire logic                             i_wb_we,
	input  wire logic [`BUS_ADR_W-1:0]            i_wb_adr,
	input  wire logic [3:0]                       i_wb_sel,
	input  wire logic [31:0]                      i_wb_dat,
	output logic      [31:0]                      o_wb_dat,
	output logic                                  o_wb_ack,
	// Encoder pins and expansion interrupt requests.
	input  wire hsc_pkg::enc_s [`NUM_CNT-1:0]     i_enc,
	input  wire hsc_pkg::ext_req_s                i_ext,
	// Interrupt task dispatch.
	output logic                                  o_suspend_cyclic,
	output logic      [7:0]                       o_task_num,
	output logic                                  o_task_ext
);
	import hsc_pkg::*;

	function automatic logic [1:0] step_dec(input logic [1:0] mode, input enc_s cur,
		input enc_s prv);
		logic [1:0] r;
		r = 2'h0;
		case (in_mode_e'(mode))
			IN_QUAD:      r = {cur.a ^ prv.a ^ cur.b ^ prv.b, ~(cur.a ^ prv.b)};
			IN_PULSE_DIR: r = {cur.a & ~prv.a, cur.b};
			IN_UP_DOWN:   r = {(cur.a & ~prv.a) ^ (cur.b & ~prv.b), cur.b & ~prv.b};
			IN_INC:       r = {cur.a & ~prv.a, 1'b0};
			default:      r = 2'h0;
		endcase
		return r;
	endfunction

	function automatic val_t count_next(input val_t v, input logic dn, input logic ring,
		input val_t max);
		val_t r;
		if (ring) begin
			if (dn) r = (v == 32'h0) ? max : v - 32'h1;
			else    r = (v >= max) ? 32'h0 : v + 32'h1;
		end else begin
			if (dn) r = (v == 32'h0) ? v : v - 32'h1;
			else    r = (&v) ? v : v + 32'h1;
		end
		return r;
	endfunction

	function automatic val_t merge(input val_t old, input val_t nw, input logic [3:0] sel);
		val_t m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// Input synchronisers; stage one feeds only stage two.
	enc_s [`NUM_CNT-1:0] enc_s1, enc_s2, enc_s3;
	ext_req_s            ext_s1, ext_s2;
	logic                ext_req_d;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			enc_s1    <= '0;
			enc_s2    <= '0;
			enc_s3    <= '0;
			ext_s1    <= '0;
			ext_s2    <= '0;
			ext_req_d <= 1'b0;
		end else begin
			enc_s1    <= i_enc;
			enc_s2    <= enc_s1;
			enc_s3    <= enc_s2;
			ext_s1    <= i_ext;
			ext_s2    <= ext_s1;
			ext_req_d <= ext_s2.req;
		end
	end

	// Bus decode.
	logic [1:0] ci;
	logic       wr, cnt_wr, glb_wr, tbl_wr, cond;
	val_t       rd;
	assign ci     = i_wb_adr[5:4];
	assign wr     = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & ~i_wb_adr[`A_HOLE_BIT];
	assign cnt_wr = wr & ~i_wb_adr[`A_WIN_BIT] & (i_wb_adr[7:6] == `A_BLK_CNT);
	assign glb_wr = wr & ~i_wb_adr[`A_WIN_BIT] & (i_wb_adr[7:6] == `A_BLK_GLB);
	assign tbl_wr = wr & i_wb_adr[`A_WIN_BIT] & (i_wb_sel[1:0] == 2'h3);
	assign cond   = i_wb_sel[1] & i_wb_dat[`CMD_COND];

	// Counter, table and scanner state.
	cfg_s  cfg [`NUM_CNT], next_cfg [`NUM_CNT];
	val_t  ring_max [`NUM_CNT], next_ring_max [`NUM_CNT];
	val_t  pv [`NUM_CNT], next_pv [`NUM_CNT];
	logic  cmp_on [`NUM_CNT], next_cmp_on [`NUM_CNT];
	logic  rng_mode [`NUM_CNT], next_rng_mode [`NUM_CNT];
	logic  dir_dn [`NUM_CNT], next_dir_dn [`NUM_CNT];
	logic  tm_valid [`NUM_CNT], next_tm_valid [`NUM_CNT];
	val_t  tm_val [`NUM_CNT], next_tm_val [`NUM_CNT];
	logic [7:0] rng_in [`NUM_CNT], next_rng_in [`NUM_CNT];
	scan_e sc_state, next_sc_state;
	logic [1:0] sc_cnt, next_sc_cnt;
	logic [`TBL_WAW-1:0] sc_word, next_sc_word;
	logic [2:0] sc_k, next_sc_k;
	logic [4:0] sc_ent, next_sc_ent;
	logic sc_hdr, next_sc_hdr;
	word_t sc_num, next_sc_num;
	word_t sc_buf [5], next_sc_buf [5];
	word_t mem_rd;
	logic  post, cnt_pend;
	logic [7:0] post_num;
	logic [1:0] fsel;

	hsc_tbl_mem #(
		.W     (16),
		.DEPTH (`TBL_DEPTH),
		.AW    (`TBL_AW)
	) u_tbl (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_we    (tbl_wr),
		.i_waddr (i_wb_adr[9:2]),
		.i_wdata (i_wb_dat[15:0]),
		.i_raddr ({sc_cnt, sc_word}),
		.o_rdata (mem_rd)
	);

	always_comb begin
		logic [1:0] st;
		logic       hit, own, last, zrst, rst, inr;
		val_t       cur, lo, hi;
		st = 2'h0; hit = 1'b0; own = 1'b0; last = 1'b0;
		zrst = 1'b0; rst = 1'b0; inr = 1'b0;
		cur = '0; lo = '0; hi = '0;
		post = 1'b0;
		post_num = 8'h0;
		next_sc_state = sc_state;
		next_sc_cnt = sc_cnt;
		next_sc_word = sc_word;
		next_sc_k = sc_k;
		next_sc_ent = sc_ent;
		next_sc_hdr = sc_hdr;
		next_sc_num = sc_num;
		next_sc_buf = sc_buf;
		for (int c = 0; c < `NUM_CNT; c++) begin
			own = cnt_wr && (ci == c[1:0]);
			next_cfg[c] = cfg[c];
			next_ring_max[c] = ring_max[c];
			next_cmp_on[c] = cmp_on[c];
			next_rng_mode[c] = rng_mode[c];
			next_dir_dn[c] = dir_dn[c];
			next_tm_val[c] = tm_val[c];
			next_rng_in[c] = rng_in[c];
			next_tm_valid[c] = tm_valid[c] && (tm_val[c] == pv[c]);
			if (own && i_wb_adr[3:2] == `A_CFG) next_cfg[c] = cfg_s'(merge(32'(cfg[c]), i_wb_dat, i_wb_sel));
			if (own && i_wb_adr[3:2] == `A_RING) next_ring_max[c] = merge(ring_max[c], i_wb_dat, i_wb_sel);
			if (own && i_wb_adr[3:2] == `A_CMD && cond) begin
				if (i_wb_dat[`CMD_TBL]) begin
					next_rng_mode[c] = i_wb_dat[`CTL_RANGE];
					next_cmp_on[c] = ~i_wb_dat[`CTL_REG_ONLY];
					next_rng_in[c] = 8'h0;
					next_tm_valid[c] = 1'b0;
				end
				if (i_wb_dat[`CMD_START]) next_cmp_on[c] = 1'b1;
				if (i_wb_dat[`CMD_STOP]) next_cmp_on[c] = 1'b0;
			end
			st = step_dec(cfg[c].mode, enc_s2[c], enc_s3[c]);
			zrst = ~cfg[c].method[`M_SWONLY] & enc_s2[c].z & ~enc_s3[c].z;
			rst = zrst | (own && i_wb_adr[3:2] == `A_CMD && cond && i_wb_dat[`CMD_SRST]);
			next_pv[c] = pv[c];
			if (rst) begin
				next_pv[c] = 32'h0;
				if (!cfg[c].method[`M_CONT]) next_cmp_on[c] = 1'b0;
			end else if (own && i_wb_adr[3:2] == `A_PV) begin
				next_pv[c] = merge(pv[c], i_wb_dat, i_wb_sel);
			end else if (cfg[c].gate && st[1]) begin
				next_pv[c] = count_next(pv[c], st[0], cfg[c].ring, ring_max[c]);
				next_dir_dn[c] = st[0];
			end
		end
		cur = pv[sc_cnt];
		case (sc_state)
			SC_IDLE: begin
				next_sc_ent = 5'h0;
				next_sc_k = 3'h0;
				next_sc_hdr = ~rng_mode[sc_cnt];
				next_sc_word = '0;
				if (cmp_on[sc_cnt]) next_sc_state = SC_ADDR;
				else next_sc_cnt = sc_cnt + 2'h1;
			end
			SC_ADDR: next_sc_state = SC_DATA;
			SC_DATA: begin
				next_sc_word = sc_word + 6'h1;
				next_sc_state = SC_ADDR;
				if (sc_hdr) begin
					next_sc_hdr = 1'b0;
					next_sc_num = (mem_rd > `MAX_TGT) ? `MAX_TGT : mem_rd;
					if (mem_rd == 16'h0) next_sc_state = SC_IDLE;
				end else begin
					next_sc_buf[sc_k] = mem_rd;
					next_sc_k = sc_k + 3'h1;
					if (sc_k == (rng_mode[sc_cnt] ? `RNG_LAST_K : `TGT_LAST_K)) begin
						next_sc_state = SC_EVAL;
					end
				end
				if (!cmp_on[sc_cnt]) next_sc_state = SC_IDLE;
			end
			SC_EVAL: begin
				lo = {sc_buf[1], sc_buf[0]};
				hi = {sc_buf[3], sc_buf[2]};
				if (rng_mode[sc_cnt]) begin
					inr = (cur >= lo) && (cur <= hi) && (sc_buf[4] != `TASK_DISABLE);
					hit = inr && !rng_in[sc_cnt][sc_ent[2:0]]
						&& (sc_buf[4] != `TASK_NOSTART);
					post_num = sc_buf[4][7:0];
					last = (sc_ent == `NUM_RNG - 5'h1);
				end else begin
					hit = (cur == lo) && (sc_buf[2][`DIR_BIT] == dir_dn[sc_cnt])
						&& !(tm_valid[sc_cnt] && tm_val[sc_cnt] == cur);
					post_num = sc_buf[2][7:0];
					last = ({11'h0, sc_ent} + 16'h1 >= sc_num);
				end
				if (!(hit && cnt_pend)) begin
					post = hit;
					if (rng_mode[sc_cnt]) next_rng_in[sc_cnt][sc_ent[2:0]] = inr;
					else if (hit) begin
						next_tm_valid[sc_cnt] = 1'b1;
						next_tm_val[sc_cnt] = cur;
					end
					next_sc_ent = sc_ent + 5'h1;
					next_sc_k = 3'h0;
					next_sc_state = SC_ADDR;
					if (last || !cmp_on[sc_cnt]) begin
						next_sc_state = SC_IDLE;
						next_sc_cnt = sc_cnt + 2'h1;
					end
				end
			end
			default: next_sc_state = SC_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int c = 0; c < `NUM_CNT; c++) begin
				cfg[c] <= '0; ring_max[c] <= '0; pv[c] <= '0; cmp_on[c] <= 1'b0;
				rng_mode[c] <= 1'b0; dir_dn[c] <= 1'b0; tm_valid[c] <= 1'b0;
				tm_val[c] <= '0; rng_in[c] <= 8'h0;
			end
			sc_state <= SC_IDLE; sc_cnt <= 2'h0; sc_word <= '0; sc_k <= 3'h0;
			sc_ent <= 5'h0; sc_hdr <= 1'b0; sc_num <= 16'h0;
			for (int i = 0; i < 5; i++) sc_buf[i] <= 16'h0;
		end else begin
			cfg <= next_cfg; ring_max <= next_ring_max; pv <= next_pv;
			cmp_on <= next_cmp_on; rng_mode <= next_rng_mode; dir_dn <= next_dir_dn;
			tm_valid <= next_tm_valid; tm_val <= next_tm_val; rng_in <= next_rng_in;
			sc_state <= next_sc_state; sc_cnt <= next_sc_cnt; sc_word <= next_sc_word;
			sc_k <= next_sc_k; sc_ent <= next_sc_ent; sc_hdr <= next_sc_hdr;
			sc_num <= next_sc_num; sc_buf <= next_sc_buf;
		end
	end

	// Task dispatch: each source keeps its own pending request, so a shared number runs twice.
	logic       ext_pend, next_ext_pend, next_cnt_pend, next_task_act, next_task_ext;
	logic [7:0] ext_num, next_ext_num, cnt_num, next_cnt_num, next_task_num;
	logic       take_ext, take_cnt, ext_evt;

	always_comb begin
		ext_evt = ext_s2.req & ~ext_req_d;
		take_ext = ~o_suspend_cyclic & ext_pend;
		take_cnt = ~o_suspend_cyclic & ~ext_pend & cnt_pend;
		next_ext_pend = (ext_pend & ~take_ext) | ext_evt;
		next_ext_num = ext_evt ? ext_s2.num : ext_num;
		next_cnt_pend = (cnt_pend & ~take_cnt) | post;
		next_cnt_num = post ? post_num : cnt_num;
		next_task_act = o_suspend_cyclic;
		next_task_num = o_task_num;
		next_task_ext = o_task_ext;
		if (glb_wr && i_wb_adr[3:2] == `A_TASK && i_wb_sel[0] && i_wb_dat[`TASK_DONE]) begin
			next_task_act = 1'b0;
		end
		if (take_ext || take_cnt) begin
			next_task_act = 1'b1;
			next_task_num = take_ext ? ext_num : cnt_num;
			next_task_ext = take_ext;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ext_pend <= 1'b0; ext_num <= 8'h0; cnt_pend <= 1'b0; cnt_num <= 8'h0;
			o_suspend_cyclic <= 1'b0; o_task_num <= 8'h0; o_task_ext <= 1'b0;
		end else begin
			ext_pend <= next_ext_pend; ext_num <= next_ext_num;
			cnt_pend <= next_cnt_pend; cnt_num <= next_cnt_num;
			o_suspend_cyclic <= next_task_act; o_task_num <= next_task_num;
			o_task_ext <= next_task_ext;
		end
	end

	// Frequency measurement on the one selected counter.
	logic [31:0] win_cnt, next_win_cnt;
	val_t        acc, next_acc, freq, next_freq;
	logic [1:0]  next_fsel;
	logic [1:0]  fst;

	always_comb begin
		fst = step_dec(cfg[fsel].mode, enc_s2[fsel], enc_s3[fsel]);
		next_fsel = fsel;
		if (glb_wr && i_wb_adr[3:2] == `A_FSEL && i_wb_sel[0]) next_fsel = i_wb_dat[1:0];
		next_acc = acc + {31'h0, fst[1]};
		next_win_cnt = win_cnt + 32'h1;
		next_freq = freq;
		if (win_cnt == 32'(FREQ_WIN_CYC - 1) || next_fsel != fsel) begin
			next_win_cnt = 32'h0;
			next_acc = 32'h0;
			if (next_fsel == fsel) next_freq = acc + {31'h0, fst[1]};
		end
	end

	// Wishbone read mux and single-wait-state acknowledge.
	always_comb begin
		rd = 32'h0;
		if (!i_wb_adr[`A_HOLE_BIT] && !i_wb_adr[`A_WIN_BIT]) begin
			if (i_wb_adr[7:6] == `A_BLK_CNT) begin
				case (i_wb_adr[3:2])
					`A_CFG:  rd = {26'h0, cfg[ci]};
					`A_RING: rd = ring_max[ci];
					`A_PV:   rd = pv[ci];
					`A_CMD:  rd = {29'h0, dir_dn[ci], rng_mode[ci], cmp_on[ci]};
					default: rd = 32'h0;
				endcase
			end else if (i_wb_adr[7:6] == `A_BLK_GLB) begin
				case (i_wb_adr[3:2])
					`A_FSEL: rd = {30'h0, fsel};
					`A_FREQ: rd = freq;
					`A_TASK: rd = {22'h0, ext_pend | cnt_pend, o_task_ext, o_task_num};
					default: rd = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wb_ack <= 1'b0; o_wb_dat <= 32'h0; fsel <= 2'h0;
			win_cnt <= 32'h0; acc <= 32'h0; freq <= 32'h0;
		end else begin
			o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
			o_wb_dat <= (i_wb_cyc & i_wb_stb & ~o_wb_ack) ? rd : 32'h0;
			fsel <= next_fsel; win_cnt <= next_win_cnt; acc <= next_acc; freq <= next_freq;
		end
	end
endmodule

// ===== rtl/hsc_map.svh
// Register offsets, field positions, codes and timing constants of the counter block.
// Assumes inclusion by the package and by the design files that decode registers.
`ifndef HSC_MAP_SVH
`define HSC_MAP_SVH

`define NUM_CNT      4
`define CLK_MHZ      125
`define FREQ_WIN_US  1000
`define BUS_ADR_W    12

`define A_WIN_BIT    10
`define A_HOLE_BIT   11
`define A_BLK_CNT    2'h0
`define A_BLK_GLB    2'h1
`define A_CFG        2'h0
`define A_RING       2'h1
`define A_PV         2'h2
`define A_CMD        2'h3
`define A_FSEL       2'h0
`define A_FREQ       2'h1
`define A_TASK       2'h2

`define CMD_TBL      4
`define CMD_START    8
`define CMD_STOP     9
`define CMD_SRST     10
`define CMD_COND     15
`define TASK_DONE    0

`define CTL_REG_ONLY 1
`define CTL_RANGE    0

`define M_SWONLY     0
`define M_CONT       1

`define TBL_AW       8
`define TBL_WAW      6
`define TBL_DEPTH    256
`define MAX_TGT      16'h0015
`define NUM_RNG      5'h08
`define TGT_LAST_K   3'h2
`define RNG_LAST_K   3'h4
`define DIR_BIT      15
`define TASK_DISABLE 16'hFFFF
`define TASK_NOSTART 16'hAAAA

`endif

// ===== rtl/hsc_pkg.sv
// Types shared by the high-speed counter block.
// Assumes the constants header is on the include path.
package hsc_pkg;
	`include "hsc_map.svh"

	typedef logic [15:0] word_t;
	typedef logic [31:0] val_t;

	typedef struct packed {
		logic z;
		logic b;
		logic a;
	} enc_s;

	typedef struct packed {
		logic       req;
		logic [7:0] num;
	} ext_req_s;

	typedef struct packed {
		logic       gate;
		logic [1:0] method;
		logic       ring;
		logic [1:0] mode;
	} cfg_s;

	typedef enum logic [1:0] {IN_QUAD, IN_PULSE_DIR, IN_UP_DOWN, IN_INC} in_mode_e;

	typedef enum logic [1:0] {SC_IDLE, SC_ADDR, SC_DATA, SC_EVAL} scan_e;
endpackage

// ===== rtl/hsc_tbl_mem.sv
// Comparison table storage: one write port, one read port with registered data.
// Assumes both ports run on the block clock; a write and a read may share a cycle.
module hsc_tbl_mem #(
	parameter int W     = 16,
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	// Clock and reset.
	input  wire logic          i_clk,
	input  wire logic          i_rst_b,
	// Write port.
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [W-1:0]  i_wdata,
	// Read port.
	input  wire logic [AW-1:0] i_raddr,
	output logic      [W-1:0]  o_rdata
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule

// ===== testbench/hs_counter_compare_irq_asserts.sv
// Concurrent checks on the bus and task dispatch ports of the counter block.
// Assumes it is bound into the top module; one clock, active-low async reset.
`include "hsc_map.svh"
module hsc_checker
	import hsc_pkg::*;
#(
	parameter int FREQ_WIN_CYC = 125000
) (
	input wire logic                    i_clk,
	input wire logic                    i_rst_b,
	input wire logic                    i_wb_cyc,
	input wire logic                    i_wb_stb,
	input wire logic                    i_wb_we,
	input wire logic [`BUS_ADR_W-1:0]   i_wb_adr,
	input wire logic [3:0]              i_wb_sel,
	input wire logic [31:0]             i_wb_dat,
	input wire logic [31:0]             o_wb_dat,
	input wire logic                    o_wb_ack,
	input wire hsc_pkg::ext_req_s       i_ext,
	input wire logic                    o_suspend_cyclic,
	input wire logic [7:0]              o_task_num,
	input wire logic                    o_task_ext
);
	timeunit 1ns;
	timeprecision 1ps;
	logic done_wr;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// Completion write to the task register ends the running task.
	assign done_wr = o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_dat[0]
		&& (i_wb_adr[11:2] == 10'h012);
	a_ack_latency: assert property ($rose(i_wb_cyc && i_wb_stb) |=> o_wb_ack)
		else $error("bus request not answered in the next cycle");
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("acknowledge longer than one cycle");
	a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("acknowledge without request");
	a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
		else $error("read data not zero outside acknowledge");
	a_hole_zero: assert property (o_wb_ack && !i_wb_we && (i_wb_adr[11] || i_wb_adr[10])
		|-> o_wb_dat == 32'h0) else $error("unmapped or table read not zero");
	a_ext_dispatch: assert property ($rose(i_ext.req) && !o_suspend_cyclic
		|-> ##[3:7] o_suspend_cyclic) else $error("expansion request not dispatched");
	a_ext_number: assert property ($rose(o_suspend_cyclic) && o_task_ext
		|-> o_task_num == i_ext.num) else $error("expansion task number wrong");
	a_task_stable: assert property (o_suspend_cyclic && $past(o_suspend_cyclic)
		|-> $stable(o_task_num) && $stable(o_task_ext)) else $error("task changed mid-run");
	a_suspend_hold: assert property (o_suspend_cyclic && !done_wr && !$past(done_wr)
		|=> o_suspend_cyclic) else $error("cyclic work resumed before completion");
	a_suspend_release: assert property (done_wr && o_suspend_cyclic
		|-> ##[1:2] !o_suspend_cyclic) else $error("cyclic work not resumed");
	c_ext: cover property ($rose(o_suspend_cyclic) && o_task_ext);
	c_cnt: cover property ($rose(o_suspend_cyclic) && !o_task_ext);
	c_done: cover property (done_wr);
endmodule

bind hs_counter_compare_irq hsc_checker #(.FREQ_WIN_CYC(FREQ_WIN_CYC)) hsc_checker_inst (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ext(i_ext),
	.o_suspend_cyclic(o_suspend_cyclic), .o_task_num(o_task_num), .o_task_ext(o_task_ext));

// ===== testbench/hsc_enc_model.sv
// Behavioural pulse source for one counter input: encoder, pulse or index.
// Assumes the caller resumes it right after a rising clock edge.
module hsc_enc_model
	import hsc_pkg::*;
#(
	parameter int HALF = 250
) (
	input  wire logic       i_clk,
	input  wire logic [1:0] i_mode,
	output hsc_pkg::enc_s   o_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase = 2'h0;
	initial o_pins = '0;
	task automatic hold();
		repeat (HALF) @(posedge i_clk);
	endtask
	task automatic index();
		o_pins.z <= 1'b1;
		hold();
		o_pins.z <= 1'b0;
		hold();
	endtask
	// Direction is set up one half period before the count edge.
	task automatic step(input logic down, input int n);
		logic sel_b;
		repeat (n) begin
			sel_b = (i_mode == 2'h2) && down;
			if (i_mode == 2'h0) begin
				phase = down ? phase - 2'h1 : phase + 2'h1;
				o_pins.a <= ^phase;
				o_pins.b <= phase[1];
			end else begin
				o_pins.b <= (i_mode == 2'h1) && down;
				hold();
				o_pins.a <= !sel_b;
				o_pins.b <= sel_b || ((i_mode == 2'h1) && down);
				hold();
				o_pins.a <= 1'b0;
				o_pins.b <= (i_mode == 2'h1) && down;
			end
			hold();
			hold();
		end
	endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the four-counter compare and task dispatch block.
// Assumes package, design, checker and encoder model are compiled first.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hsc_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic        i_wb_cyc = 1'b0;
	logic        i_wb_stb = 1'b0;
	logic        i_wb_we = 1'b0;
	logic [11:0] i_wb_adr = '0;
	logic [3:0]  i_wb_sel = '0;
	logic [31:0] i_wb_dat = '0;
	logic [31:0] o_wb_dat;
	logic        o_wb_ack;
	enc_s [3:0]  i_enc;
	ext_req_s    i_ext = '0;
	logic        o_suspend_cyclic;
	logic [7:0]  o_task_num;
	logic        o_task_ext;
	logic [1:0]  enc_mode [4] = '{default: 2'h0};
	logic [31:0] q;
	logic [31:0] fmax = '0;
	word_t       rq [$];
	int          n_fail = 0;
	int          n_checks = 0;

	hs_counter_compare_irq #(.FREQ_WIN_CYC(50)) hs_counter_compare_irq_inst (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_enc(i_enc), .i_ext(i_ext),
		.o_suspend_cyclic(o_suspend_cyclic), .o_task_num(o_task_num), .o_task_ext(o_task_ext));
	for (genvar g = 0; g < 4; g++) begin : g_enc
		hsc_enc_model enc (.i_clk(i_clk), .i_mode(enc_mode[g]), .o_pins(i_enc[g]));
	end
	always #4 i_clk = ~i_clk;

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= a;
		i_wb_sel <= 4'hF;
		i_wb_dat <= d;
		do begin
			@(posedge i_clk);
			t++;
		end while (o_wb_ack !== 1'b1 && t < 40);
		chk("ack", 32'h1, {31'h0, o_wb_ack});
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(name, exp, q);
	endtask
	task automatic tbl(input int n, input word_t w[$]);
		foreach (w[i]) wr(12'h400 + 12'(4 * (64 * n + i)), {16'h0, w[i]});
	endtask
	// Waits for a dispatched task, checks it, then signals its completion.
	task automatic tsk(input logic [7:0] num, input logic ext);
		int t;
		t = 0;
		while (o_suspend_cyclic !== 1'b1 && t < 4000) begin
			@(posedge i_clk);
			t++;
		end
		chk("suspend_up", 32'h1, {31'h0, o_suspend_cyclic});
		chk("task_num", {24'h0, num}, {24'h0, o_task_num});
		chk("task_ext", {31'h0, ext}, {31'h0, o_task_ext});
		wr(12'h048, 32'h1);
		// Looked at before a second pending task can be launched.
		chk("suspend_down", 32'h0, {31'h0, o_suspend_cyclic});
	endtask

	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		rdc("cfg0", 12'h000, 32'h0);
		rdc("pv0", 12'h008, 32'h0);
		rdc("cmd0", 12'h00C, 32'h0);
		wr(12'h800, 32'hFFFFFFFF);
		rdc("hole", 12'h800, 32'h0);
		rdc("window", 12'h404, 32'h0);
		$display("test reset done");
		enc_mode[0] = 2'h2;
		wr(12'h000, 32'h0000002A);
		tbl(0, {16'h0002, 16'h0003, 16'h0000, 16'h000A, 16'h0001, 16'h0000, 16'h800B});
		wr(12'h00C, 32'h00000010);
		rdc("cmd_nocond", 12'h00C, 32'h0);
		wr(12'h00C, 32'h00008010);
		rdc("cmd_on", 12'h00C, 32'h1);
		g_enc[0].enc.step(1'b0, 3);
		tsk(8'h0A, 1'b0);
		rdc("pv0_up", 12'h008, 32'h3);
		g_enc[0].enc.step(1'b1, 2);
		tsk(8'h0B, 1'b0);
		rdc("cmd_dir", 12'h00C, 32'h5);
		wr(12'h00C, 32'h00008400);
		rdc("pv0_srst", 12'h008, 32'h0);
		wb(1'b0, 12'h00C, 32'h0);
		chk("cmp_stopped", 32'h0, {31'h0, q[0]});
		wr(12'h00C, 32'h00008012);
		rdc("cmd_regonly", 12'h00C, 32'h4);
		wr(12'h00C, 32'h00008100);
		rdc("cmd_start", 12'h00C, 32'h5);
		wr(12'h00C, 32'h00008200);
		rdc("cmd_stop", 12'h00C, 32'h4);
		$display("test target done");
		enc_mode[1] = 2'h3;
		wr(12'h010, 32'h0000003F);
		wr(12'h014, 32'h00000003);
		rq = {16'h0002, 16'h0000, 16'h0002, 16'h0000, 16'h000C};
		rq = {rq, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hAAAA};
		repeat (6) rq = {rq, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF};
		tbl(1, rq);
		wr(12'h01C, 32'h00008011);
		rdc("cmd1_on", 12'h01C, 32'h3);
		g_enc[1].enc.step(1'b0, 2);
		tsk(8'h0C, 1'b0);
		g_enc[1].enc.step(1'b0, 2);
		rdc("pv1_wrap", 12'h018, 32'h0);
		chk("no_task", 32'h0, {31'h0, o_suspend_cyclic});
		wr(12'h01C, 32'h00008400);
		wb(1'b0, 12'h01C, 32'h0);
		chk("cmp_cont", 32'h1, {31'h0, q[0]});
		$display("test range done");
		enc_mode[2] = 2'h1;
		wr(12'h020, 32'h00000021);
		g_enc[2].enc.step(1'b0, 2);
		rdc("pv2", 12'h028, 32'h2);
		g_enc[2].enc.index();
		rdc("pv2_index", 12'h028, 32'h0);
		wr(12'h020, 32'h00000001);
		g_enc[2].enc.step(1'b0, 2);
		rdc("pv2_hold", 12'h028, 32'h0);
		wr(12'h040, 32'h00000002);
		rdc("fsel", 12'h040, 32'h2);
		// One pulse falls in one measuring window, so the largest reading is one.
		fork
			g_enc[2].enc.step(1'b0, 1);
			repeat (200) begin
				wb(1'b0, 12'h044, 32'h0);
				if (q > fmax) fmax = q;
			end
		join
		chk("freq", 32'h1, fmax);
		$display("test index done");
		wr(12'h030, 32'h00000020);
		wr(12'h038, 32'hFFFFFFFE);
		g_enc[3].enc.step(1'b0, 3);
		rdc("pv3_top", 12'h038, 32'hFFFFFFFF);
		g_enc[3].enc.step(1'b1, 2);
		rdc("pv3_down", 12'h038, 32'hFFFFFFFD);
		rdc("pv1_indep", 12'h018, 32'h0);
		$display("test linear done");
		i_ext.num <= 8'h0C;
		@(posedge i_clk);
		i_ext.req <= 1'b1;
		g_enc[1].enc.step(1'b0, 2);
		tsk(8'h0C, 1'b1);
		tsk(8'h0C, 1'b0);
		i_ext.req <= 1'b0;
		$display("test external done");
		results();
	end
	initial begin
		repeat (80000) @(posedge i_clk);
		n_fail++;
		results();
	end
endmodule
